// *** msd_map.vh ***
// Constants for the switch status and analog select register block.
// Assumes a 50 MHz mclk and 32-bit frames on the serial link.
`ifndef MSD_MAP_VH
`define MSD_MAP_VH

// ----------------------------------------------------------------
// Register addresses (frame bits 31..25)
// ----------------------------------------------------------------
`define MSD_ADDR_ANALOG 7'h1d
`define MSD_ADDR_STATUS 7'h1f
`define MSD_ADDR_FAULT 7'h21

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define MSD_FRAME_BITS 6'h20
`define MSD_ADDR_HI 31
`define MSD_ADDR_LO 25
`define MSD_RW_BIT 24
`define MSD_FLD_FAULT 23
`define MSD_FLD_INT 22
`define MSD_FLD_CUR 6
`define MSD_SEL_HI 5
`define MSD_SEL_LO 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MSD_SEL_RST 6'h00
`define MSD_CUR_RST 1'b0
`define MSD_POR_FLAG_RST 1'b1

// ----------------------------------------------------------------
// Analog channel codes
// ----------------------------------------------------------------
`define MSD_CODE_NONE 6'h00
`define MSD_CODE_GND0 6'h01
`define MSD_CODE_PRG0 6'h0f
`define MSD_CODE_TEMP 6'h17
`define MSD_CODE_BATT 6'h18

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MSD_MCLK_HZ 50000000
// Interrupt pin release delay in mclk cycles (1.0 ms)
`define MSD_INT_REL_CYCLES 50000

`endif

// *** msd_pin_sync.v ***
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs are asynchronous to mclk.
`timescale 1ns/1ns
`default_nettype none

module msd_pin_sync #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   // Clock and reset
   input wire mclk,
   input wire reset_n,
   // Pins and filtered levels
   input wire [W-1:0] pin_in,
   output wire [W-1:0] level_out
);

   // ----------------------------------------------------------------
   // Per-bit stages
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         reg s1_r;
         reg s2_r;
         reg s3_r;
         reg lvl_r;
         always @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
               s1_r <= INIT[i];
               s2_r <= INIT[i];
               s3_r <= INIT[i];
               lvl_r <= INIT[i];
            end else begin
               s1_r <= pin_in[i];
               s2_r <= s1_r;
               s3_r <= s2_r;
               // Change counts only once stages two and three agree
               if (s2_r == s3_r) begin
                  lvl_r <= s3_r;
               end
            end
         end
         assign level_out[i] = lvl_r;
      end
   endgenerate

endmodule // msd_pin_sync

`default_nettype wire

// *** msd_status_analog_mux_out.v ***
// Switch status readback and analog select register over the serial link.
// Assumes a host as link master, sclk idle low, data sampled on rising sclk,
// and switch and fault levels already resolved to logic levels.
//
// Overview of operation
// - Analog select clears at power up
// - Bit 6 picks hi-Z or wetting current
// - Bits 5..0 pick one of 24 sources
// - Analog-selected input reads 0 in status
// - Analog select writable anytime in Normal mode
// - Status register read-only, returned next frame
// - Bits 21..14 programmable, 13..0 ground inputs
// - Status bit 1 closed, 0 open
// - Fault bit ORs extended and wetting faults
// - Interrupt flag sets on any event
// - Fault and interrupt flags set after reset
// - Any returning frame clears interrupt flag
// - Persisting fault does not re-raise interrupt
// - Fault bit held until fault register read
// - Present fault sets fault bit again
// - Bits 23, 22 carry flags in replies
// - Chip select falls, then 32 clocks
// - Interrupt pin released 1 ms after select
`timescale 1ns/1ns
`default_nettype none
`include "msd_map.vh"

module msd_status_analog_mux_out #(
   parameter integer REL_CYCLES = `MSD_INT_REL_CYCLES
) (
   // Clock and reset
   input wire mclk,
   input wire reset_n,
   // Serial link pins
   input wire spi_cs_n,
   input wire spi_sclk,
   input wire spi_mosi,
   output reg spi_miso,
   output reg spi_miso_oe,
   // Switch inputs
   input wire [13:0] ground_switch_input,
   input wire [7:0] programmable_switch_input,
   // Device mode and fault conditions
   input wire normal_mode,
   input wire [7:0] ext_status_in,
   input wire [7:0] wet_fault_in,
   // Interrupt pin
   output reg int_n,
   // Analog multiplexer control
   output reg [5:0] analog_mux_sel,
   output reg analog_source_current_sel,
   output reg [23:0] analog_mux_route,
   // Flag observation
   output reg fault_status,
   output reg int_flag
);

   // ----------------------------------------------------------------
   // Local constants
   // ----------------------------------------------------------------
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_SHIFT = 2'b10;
   localparam integer REL_LAST = REL_CYCLES - 1;

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   wire [2:0] link_lvl;
   wire [21:0] sw_lvl;
   wire cs_lvl;
   wire sclk_lvl;
   wire mosi_lvl;

   msd_pin_sync #(
      .W(3),
      .INIT(3'b100)
   ) u_link_sync (
      .mclk(mclk),
      .reset_n(reset_n),
      .pin_in({spi_cs_n, spi_sclk, spi_mosi}),
      .level_out(link_lvl)
   );

   msd_pin_sync #(
      .W(22),
      .INIT(22'h00_0000)
   ) u_sw_sync (
      .mclk(mclk),
      .reset_n(reset_n),
      .pin_in({programmable_switch_input, ground_switch_input}),
      .level_out(sw_lvl)
   );

   assign cs_lvl = link_lvl[2];
   assign sclk_lvl = link_lvl[1];
   assign mosi_lvl = link_lvl[0];

   // ----------------------------------------------------------------
   // Edge detection
   // ----------------------------------------------------------------
   reg cs_d_r;
   reg sclk_d_r;
   reg [21:0] sw_d_r;
   reg [15:0] src_d_r;
   wire cs_fall;
   wire cs_rise;
   wire sclk_rise;
   wire sclk_fall;
   wire [15:0] fault_src;
   wire sw_change;
   wire fault_rise;

   assign cs_fall = cs_d_r & ~cs_lvl;
   assign cs_rise = ~cs_d_r & cs_lvl;
   assign sclk_rise = ~sclk_d_r & sclk_lvl & ~cs_lvl;
   assign sclk_fall = sclk_d_r & ~sclk_lvl & ~cs_lvl;
   assign fault_src = {wet_fault_in, ext_status_in};
   assign sw_change = |(sw_lvl ^ sw_d_r);
   assign fault_rise = |(fault_src & ~src_d_r);

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cs_d_r <= 1'b1;
         sclk_d_r <= 1'b0;
         sw_d_r <= 22'h00_0000;
         src_d_r <= 16'h0000;
      end else begin
         cs_d_r <= cs_lvl;
         sclk_d_r <= sclk_lvl;
         sw_d_r <= sw_lvl;
         src_d_r <= fault_src;
      end
   end

   // ----------------------------------------------------------------
   // Frame state machine
   // ----------------------------------------------------------------
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [5:0] bit_cnt_r;
   reg [31:0] rx_r;
   reg frame_ok;

   always @* begin
      state_nxt = state_r;
      frame_ok = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (cs_fall) begin
               state_nxt = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (cs_rise) begin
               state_nxt = ST_IDLE;
               frame_ok = (bit_cnt_r == `MSD_FRAME_BITS);
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= ST_IDLE;
         bit_cnt_r <= 6'h00;
         rx_r <= 32'h0000_0000;
      end else begin
         state_r <= state_nxt;
         if (cs_fall) begin
            bit_cnt_r <= 6'h00;
         end else if (sclk_rise && state_r == ST_SHIFT) begin
            rx_r <= {rx_r[30:0], mosi_lvl};
            if (bit_cnt_r != 6'h3f) begin
               bit_cnt_r <= bit_cnt_r + 6'h01;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   wire [6:0] cmd_addr;
   wire cmd_wr;
   wire analog_wr;
   wire fault_clr;

   assign cmd_addr = rx_r[`MSD_ADDR_HI:`MSD_ADDR_LO];
   assign cmd_wr = rx_r[`MSD_RW_BIT];
   assign analog_wr = frame_ok & cmd_wr & normal_mode &
                      (cmd_addr == `MSD_ADDR_ANALOG);
   assign fault_clr = frame_ok & ~cmd_wr &
                      (cmd_addr == `MSD_ADDR_FAULT);

   // ----------------------------------------------------------------
   // Analog select register
   // ----------------------------------------------------------------
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         analog_mux_sel <= `MSD_SEL_RST;
         analog_source_current_sel <= `MSD_CUR_RST;
      end else if (analog_wr) begin
         analog_mux_sel <= rx_r[`MSD_SEL_HI:`MSD_SEL_LO];
         analog_source_current_sel <= rx_r[`MSD_FLD_CUR];
      end
   end

   // One select line per source; codes above 24 route nothing
   wire [23:0] route_nxt;
   genvar k;
   generate
      for (k = 0; k < 24; k = k + 1) begin : g_route
         assign route_nxt[k] =
            ({26'h000_0000, analog_mux_sel} == `MSD_CODE_GND0 + k);
      end
   endgenerate

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         analog_mux_route <= 24'h00_0000;
      end else begin
         analog_mux_route <= route_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Fault and interrupt flags
   // ----------------------------------------------------------------
   reg fault_nxt;
   reg int_flag_nxt;
   wire int_event;

   assign int_event = sw_change | fault_rise;

   always @* begin
      // Source still present wins over the clear
      fault_nxt = (fault_status & ~fault_clr) | (|fault_src);
      int_flag_nxt = int_flag;
      if (int_event) begin
         int_flag_nxt = 1'b1;
      end else if (cs_fall) begin
         int_flag_nxt = 1'b0;
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         fault_status <= `MSD_POR_FLAG_RST;
         int_flag <= `MSD_POR_FLAG_RST;
      end else begin
         fault_status <= fault_nxt;
         int_flag <= int_flag_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt pin and release timer
   // ----------------------------------------------------------------
   reg int_req_r;
   reg rel_run_r;
   reg [15:0] rel_cnt_r;
   wire rel_done;

   assign rel_done = rel_run_r & ({16'h0000, rel_cnt_r} == REL_LAST);

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         int_req_r <= 1'b1;
         rel_run_r <= 1'b0;
         rel_cnt_r <= 16'h0000;
         int_n <= 1'b0;
      end else begin
         if (cs_fall && int_req_r) begin
            rel_run_r <= 1'b1;
            rel_cnt_r <= 16'h0000;
         end else if (rel_done) begin
            rel_run_r <= 1'b0;
         end else if (rel_run_r) begin
            rel_cnt_r <= rel_cnt_r + 16'h0001;
         end
         if (int_event) begin
            int_req_r <= 1'b1;
            int_n <= 1'b0;
         end else if (rel_done) begin
            int_req_r <= 1'b0;
            int_n <= 1'b1;
         end else begin
            int_n <= ~int_req_r;
         end
      end
   end

   // ----------------------------------------------------------------
   // Reply word
   // ----------------------------------------------------------------
   reg [6:0] last_addr_r;
   reg last_wr_r;
   reg [21:0] reply_data;
   wire [21:0] sw_masked;
   wire [31:0] reply;

   // Input under analog reading reports open
   assign sw_masked = sw_lvl & ~analog_mux_route[21:0];

   always @* begin
      reply_data = 22'h00_0000;
      if (last_addr_r == `MSD_ADDR_STATUS) begin
         reply_data = sw_masked;
      end else if (last_addr_r == `MSD_ADDR_ANALOG) begin
         reply_data = {15'h0000, analog_source_current_sel,
                       analog_mux_sel};
      end
   end

   // Flags ride in bits 23 and 22 of every reply
   assign reply = {last_addr_r, last_wr_r, fault_status, int_flag,
                   reply_data};

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         last_addr_r <= 7'h00;
         last_wr_r <= 1'b0;
      end else if (frame_ok) begin
         last_addr_r <= cmd_addr;
         last_wr_r <= cmd_wr;
      end
   end

   // ----------------------------------------------------------------
   // MISO shifter
   // ----------------------------------------------------------------
   reg [31:0] tx_r;

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tx_r <= 32'h0000_0000;
         spi_miso <= 1'b0;
         spi_miso_oe <= 1'b0;
      end else begin
         if (cs_fall) begin
            tx_r <= reply;
            spi_miso <= reply[31];
            spi_miso_oe <= 1'b1;
         end else if (cs_rise) begin
            spi_miso_oe <= 1'b0;
            spi_miso <= 1'b0;
         end else if (sclk_fall && state_r == ST_SHIFT) begin
            tx_r <= {tx_r[30:0], 1'b0};
            spi_miso <= tx_r[30];
         end
      end
   end

endmodule // msd_status_analog_mux_out

`default_nettype wire

// *** msd_status_analog_mux_out_chk.sv ***
// Checker for the switch status and analog select block.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/1ns
`default_nettype none

module msd_status_analog_mux_out_chk #(
   parameter integer REL_CYCLES = 50000
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Link and conditions
   input wire logic spi_cs_n,
   input wire logic spi_miso_oe,
   input wire logic normal_mode,
   input wire logic [7:0] ext_status_in,
   input wire logic [7:0] wet_fault_in,
   // Observed outputs
   input wire logic int_n,
   input wire logic [5:0] analog_mux_sel,
   input wire logic [23:0] analog_mux_route,
   input wire logic fault_status,
   input wire logic int_flag
);
   localparam int RLO = REL_CYCLES - 3;
   localparam int RHI = REL_CYCLES + 3;
   logic oe_q_r;
   int since_r;

   function automatic logic [23:0] dec(input logic [5:0] c);
      dec = (c == 6'h00 || c > 6'h18) ? 24'h00_0000 : 24'h00_0001 << (c - 6'h01);
   endfunction

   // Cycles since the reply driver switched on
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         oe_q_r <= 1'b0;
         since_r <= 0;
      end else begin
         oe_q_r <= spi_miso_oe;
         since_r <= (spi_miso_oe && !oe_q_r) ? 1 :
                    ((since_r < RHI + 10) ? since_r + 1 : since_r);
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);

   a_route_decode: assert property (
      analog_mux_route == dec($past(analog_mux_sel))) else $error("route mismatch");
   a_oe_idle: assert property (
      spi_cs_n [*8] |-> !spi_miso_oe) else $error("miso driven while idle");
   a_oe_frame: assert property (
      !spi_cs_n [*8] |-> spi_miso_oe) else $error("miso not driven in frame");
   a_fault_src: assert property (
      (|ext_status_in || |wet_fault_in) |=> fault_status) else $error("fault bit missing");
   a_fault_hold: assert property (
      $fell(fault_status) |-> spi_cs_n && $past(ext_status_in) == 8'h00
         && $past(wet_fault_in) == 8'h00) else $error("fault bit dropped");
   a_int_set: assert property (
      $rose(|ext_status_in) |-> ##[1:2] int_flag) else $error("int flag not set");
   a_int_pin: assert property (
      $rose(|ext_status_in) |-> ##[1:2] !int_n) else $error("int pin not asserted");
   a_int_clear: assert property (
      $fell(int_flag) |-> spi_miso_oe) else $error("int flag cleared outside frame");
   a_int_release: assert property (
      $rose(int_n) |-> since_r >= RLO && since_r <= RHI) else $error("int pin release time");
   a_sel_hold: assert property (
      !$stable(analog_mux_sel) |-> spi_cs_n && $past(normal_mode)) else $error("sel changed");

   c_fault_clear: cover property ($fell(fault_status));
   c_int_release: cover property ($rose(int_n));
   c_battery: cover property (analog_mux_route[23]);
endmodule // msd_status_analog_mux_out_chk

bind msd_status_analog_mux_out msd_status_analog_mux_out_chk #(.REL_CYCLES(REL_CYCLES)) u_msd_status_analog_mux_out_chk (
   .mclk(mclk), .reset_n(reset_n), .spi_cs_n(spi_cs_n), .spi_miso_oe(spi_miso_oe),
   .normal_mode(normal_mode), .ext_status_in(ext_status_in), .wet_fault_in(wet_fault_in),
   .int_n(int_n), .analog_mux_sel(analog_mux_sel), .analog_mux_route(analog_mux_route),
   .fault_status(fault_status), .int_flag(int_flag));
`default_nettype wire

// *** msd_host_model.sv ***
// Host link master model: one frame per task call.
// Assumes sclk of 160 ns, idle low, reply taken late in the high phase.
`timescale 1ns/1ns
`default_nettype none

module msd_host_model (
   // Link pins
   output logic spi_cs_n,
   output logic spi_sclk,
   output logic spi_mosi,
   input wire logic spi_miso
);
   initial begin
      spi_cs_n = 1'b1;
      spi_sclk = 1'b0;
      spi_mosi = 1'b0;
   end

   task automatic frame(input logic [31:0] tx, input int nb, output logic [31:0] rx);
      int i;
      rx = 32'h0000_0000;
      spi_cs_n = 1'b0;
      #200;
      for (i = 0; i < nb; i++) begin
         spi_mosi = tx[31 - i];
         #60;
         spi_sclk = 1'b1;
         #70;
         rx = {rx[30:0], spi_miso};
         #10;
         spi_sclk = 1'b0;
         #20;
      end
      #100;
      spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi;
      #200;
   endtask
endmodule // msd_host_model
`default_nettype wire

// *** test_switch_status_analog_mux_out.sv ***
// Self-checking bench for the switch status and analog select block.
// Assumes the host model drives the link pins and MISO has a pull-up.
`timescale 1ns/1ns
`default_nettype none
`include "msd_map.vh"

module test_switch_status_analog_mux_out_select;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic normal_mode = 1'b1;
   logic [13:0] sg = 14'h0000;
   logic [7:0] sp = 8'h00;
   logic [7:0] ext = 8'h00;
   logic [7:0] wet = 8'h00;
   wire cs_n, sclk, mosi, miso, oe, int_n, cur, fs, ifl;
   wire [5:0] sel;
   wire [23:0] route;
   wire miso_w = oe ? miso : 1'b1;
   int n_errors = 0;
   int cmp_count = 0;
   int i;
   logic [31:0] rx;

   always #10 mclk = ~mclk;

   msd_status_analog_mux_out #(.REL_CYCLES(20)) u_msd_status_analog_mux_out (.mclk(mclk), .reset_n(reset_n),
      .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(oe),
      .ground_switch_input(sg), .programmable_switch_input(sp), .normal_mode(normal_mode),
      .ext_status_in(ext), .wet_fault_in(wet), .int_n(int_n), .analog_mux_sel(sel),
      .analog_source_current_sel(cur), .analog_mux_route(route), .fault_status(fs),
      .int_flag(ifl));
   msd_host_model u_msd_host_model (.spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi),
      .spi_miso(miso_w));

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task xf(input logic [6:0] a, input logic w, input logic [23:0] d);
      u_msd_host_model.frame({a, w, d}, 32, rx);
      cyc(2);
   endtask

   task give_verdict;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task t_power;
      chk(sel, 6'h00);
      chk(cur, 1'b0);
      chk(route, 24'h00_0000);
      chk(fs, 1'b1);
      chk(ifl, 1'b1);
      xf(`MSD_ADDR_STATUS, 1'b0, 24'h00_0000);
      chk(rx[23:22], 2'b11);
      chk(ifl, 1'b0);
      chk(fs, 1'b1);
      chk(int_n, 1'b1);
      $display("power-up test done");
   endtask

   task t_switch;
      sp = 8'ha5;
      sg = 14'h1c3a;
      cyc(10);
      chk(ifl, 1'b1);
      chk(int_n, 1'b0);
      xf(`MSD_ADDR_STATUS, 1'b0, 24'h00_0000);
      chk(rx[22], 1'b1);
      xf(`MSD_ADDR_STATUS, 1'b0, 24'h00_0000);
      chk(rx[22], 1'b0);
      chk(rx[21:0], {sp, sg});
      $display("switch status test done");
   endtask

   task t_analog;
      for (i = 0; i <= 24; i++) begin
         xf(`MSD_ADDR_ANALOG, 1'b1, {17'h0_0000, i[0], i[5:0]});
         chk(sel, i[5:0]);
         chk(cur, i[0]);
         chk(route, (i == 0) ? 24'h00_0000 : 24'h00_0001 << (i - 1));
      end
      xf(`MSD_ADDR_ANALOG, 1'b1, {17'h0_0000, 1'b1, 6'h04});
      xf(`MSD_ADDR_STATUS, 1'b0, 24'h00_0000);
      chk(rx[6:0], 7'h44);
      xf(`MSD_ADDR_STATUS, 1'b0, 24'h00_0000);
      chk(rx[21:0], {sp, sg & 14'h3ff7});
      normal_mode = 1'b0;
      xf(`MSD_ADDR_ANALOG, 1'b1, {18'h0_0000, 6'h18});
      chk(sel, 6'h04);
      normal_mode = 1'b1;
      u_msd_host_model.frame({`MSD_ADDR_ANALOG, 1'b1, 18'h0_0000, 6'h09}, 31, rx);
      cyc(2);
      chk(sel, 6'h04);
      xf(`MSD_ADDR_ANALOG, 1'b1, 24'h00_0000);
      $display("analog select test done");
   endtask

   task t_fault;
      ext = 8'h04;
      cyc(3);
      chk(ifl, 1'b1);
      chk(fs, 1'b1);
      xf(`MSD_ADDR_STATUS, 1'b0, 24'h00_0000);
      cyc(20);
      chk(ifl, 1'b0);
      xf(`MSD_ADDR_FAULT, 1'b0, 24'h00_0000);
      chk(fs, 1'b1);
      ext = 8'h00;
      cyc(3);
      chk(fs, 1'b1);
      xf(`MSD_ADDR_FAULT, 1'b0, 24'h00_0000);
      chk(fs, 1'b0);
      wet = 8'h20;
      cyc(3);
      chk(fs, 1'b1);
      wet = 8'h00;
      xf(`MSD_ADDR_FAULT, 1'b0, 24'h00_0000);
      chk(fs, 1'b0);
      $display("fault flag test done");
   endtask

   initial begin
      repeat (4) @(posedge mclk);
      #1;
      reset_n = 1'b1;
      cyc(5);
      t_power;
      t_switch;
      t_analog;
      t_fault;
      give_verdict;
   end

   initial begin
      #1_000_000;
      n_errors++;
      give_verdict;
   end
endmodule // test_switch_status_analog_mux_out_select
`default_nettype wire
